// *** fpx_dpath_model.sv ***
// Datapath model feeding the exception unit
`default_nettype none
module fpx_dpath_model (
    input  wire logic        pclk,
    output logic             req_valid,
    output fpx_pkg::fpx_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    import fpx_pkg::*;
    initial {req_valid, req} = '0;
    // Scrambled after the pulse so stale fields never look valid
    task automatic send(input fpx_req_t r);
        req_valid <= 1'b1;
        req       <= r;
        @(posedge pclk);
        req_valid <= 1'b0;
        req       <= ~r;
    endtask : send
endmodule : fpx_dpath_model
`default_nettype wire

// *** fpx_exception_unit.sv ***
// Floating-point exception detection and resolution with APB arithmetic controls
//
// Overview of operation
// - Invalid on SNaN, inf sums, 0*inf, 0/0.
// - Invalid on bad remainder, sqrt, conversion, trig, compare.
// - Invalid on bad log and log-epsilon operands.
// - Masked invalid, float result: standard QNaN, flag.
// - Masked invalid, integer result: most negative integer.
// - Unmasked invalid: no store, flag kept, fault.
// - Zero-divide when finite operands give infinity.
// - Zero-divide: signed infinity and flag, else fault.
// - Overflow past format maximum; never on integer conversion.
// - Masked overflow: store rounded result, set flag.
// - Unmasked overflow: extended record, precision-trimmed fraction.
// - Huge exponent: subtract bias adjust, mark record.
// - Massive scale result: signed infinity or zero.
// - Masked underflow: denormalize; inexact sets flag.
// - Unmasked underflow: no store, record, fault.
// - Tiny exponent: add bias adjust, mark record.
// - Tininess after rounding; denormal loss is inexact.
// - Inexact on rounding loss or masked overflow.
// - Masked inexact: store rounded result, set flag.
// - Unmasked inexact alone: store and fault in the same cycle.
// - Unmasked inexact with over/underflow: record, fault.
// - Flags sticky; only software or reset clears them.
// - Standard QNaN significand is 1.1000...0.
//
// The register offsets and the APB register port were chosen for this implementation.
`default_nettype none
`include "fpx_params.svh"

module fpx_exception_unit (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              req_valid,
    input  wire fpx_pkg::fpx_req_t req,
    output fpx_pkg::fpx_dst_t      dst,
    output fpx_pkg::fpx_fault_t    fault,
    output logic      [1:0]        round_mode
);
    import fpx_pkg::*;

    // Operand class helper
    function automatic logic is_fin(input fpx_cls_t c);
        return !c.nan && !c.inf;
    endfunction : is_fin

    function automatic logic is_neg_nz(input fpx_cls_t c);
        return c.neg && !c.zero && !c.nan;
    endfunction : is_neg_nz

    function automatic fpx_exp_t fmt_emax(input fpx_fmt_t f);
        case (f)
            FPX_FMT_SGL: return `FPX_SGL_EMAX;
            FPX_FMT_DBL: return `FPX_DBL_EMAX;
            default:     return `FPX_EXT_EMAX;
        endcase
    endfunction : fmt_emax

    function automatic fpx_exp_t fmt_emin(input fpx_fmt_t f);
        case (f)
            FPX_FMT_SGL: return `FPX_SGL_EMIN;
            FPX_FMT_DBL: return `FPX_DBL_EMIN;
            default:     return `FPX_EXT_EMIN;
        endcase
    endfunction : fmt_emin

    // Encodings are right-aligned in the 80-bit destination word
    function automatic logic [79:0] inf_enc(input fpx_fmt_t f, input logic s);
        logic [79:0] v;
        v = `FPX_INF_EXT;
        case (f)
            FPX_FMT_SGL: v = `FPX_INF_SGL | {48'h0, s, 31'h0};
            FPX_FMT_DBL: v = `FPX_INF_DBL | {16'h0, s, 63'h0};
            default:     v = `FPX_INF_EXT | {s, 79'h0};
        endcase
        return v;
    endfunction : inf_enc

    function automatic logic [79:0] qnan_enc(input fpx_fmt_t f);
        case (f)
            FPX_FMT_SGL: return `FPX_QNAN_SGL;
            FPX_FMT_DBL: return `FPX_QNAN_DBL;
            default:     return `FPX_QNAN_EXT;
        endcase
    endfunction : qnan_enc

    function automatic logic [63:0] sig_keep(input fpx_fmt_t f);
        case (f)
            FPX_FMT_SGL: return `FPX_SIG_KEEP_SGL;
            FPX_FMT_DBL: return `FPX_SIG_KEEP_DBL;
            default:     return {64{1'b1}};
        endcase
    endfunction : sig_keep

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : hit

    // Register state
    logic [`FPX_NUM_EXC-1:0] mask_q;
    logic [1:0]              rm_q;
    logic [`FPX_NUM_EXC-1:0] flag_q;
    fpx_rec_t                rec_q;
    fpx_flt_t                fcode_q;
    fpx_dst_t                dst_q;
    fpx_fault_t              fault_q;
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic                    pslverr_q;

    // Bus decode
    logic        acc_done;
    logic        wr_done;
    logic        mapped;
    logic [31:0] rd_d;

    assign acc_done = psel && penable && pready_q;
    assign wr_done  = acc_done && pwrite && mapped;

    always_comb begin
        mapped = hit(paddr, `FPX_OFF_ARITH_CTRL) || hit(paddr, `FPX_OFF_FLAGS)
              || hit(paddr, `FPX_OFF_FINFO) || hit(paddr, `FPX_OFF_FEXP)
              || hit(paddr, `FPX_OFF_FSIG_LO) || hit(paddr, `FPX_OFF_FSIG_HI);
        rd_d = 32'h0000_0000;
        if (hit(paddr, `FPX_OFF_ARITH_CTRL)) begin
            rd_d[`FPX_NUM_EXC-1:0]       = mask_q;
            rd_d[`FPX_RM_HI:`FPX_RM_LO]  = rm_q;
        end else if (hit(paddr, `FPX_OFF_FLAGS)) begin
            rd_d[`FPX_NUM_EXC-1:0] = flag_q;
        end else if (hit(paddr, `FPX_OFF_FINFO)) begin
            rd_d[2:0] = fcode_q;
            rd_d[`FPX_FFLAGS_LO + `FPX_BIAS_ADJ_BIT] = rec_q.bias_adj;
        end else if (hit(paddr, `FPX_OFF_FEXP)) begin
            rd_d[15:0] = {rec_q.sign, rec_q.exp};
        end else if (hit(paddr, `FPX_OFF_FSIG_LO)) begin
            rd_d = rec_q.sig[31:0];
        end else if (hit(paddr, `FPX_OFF_FSIG_HI)) begin
            rd_d = rec_q.sig[63:32];
        end
    end

    // Exception classification
    logic     inv;
    logic     zdiv;
    logic     ovf;
    logic     unf;
    logic     zsign;
    fpx_exp_t e_adj;
    fpx_exp_t e_bsd;
    logic     badj;
    logic     massive_big;
    logic     massive_small;
    fpx_rec_t rec_d;

    always_comb begin
        inv = req.x.snan || req.y.snan;
        case (req.op)
            FPX_OP_ADD:   inv = inv || (req.x.inf && req.y.inf && (req.x.neg != req.y.neg));
            FPX_OP_SUB:   inv = inv || (req.x.inf && req.y.inf && (req.x.neg == req.y.neg));
            FPX_OP_MUL:   inv = inv || (req.x.zero && req.y.inf) || (req.x.inf && req.y.zero);
            FPX_OP_DIV:   inv = inv || (req.x.zero && req.y.zero) || (req.x.inf && req.y.inf);
            FPX_OP_REM:   inv = inv || req.y.zero || req.x.inf;
            FPX_OP_SQRT:  inv = inv || is_neg_nz(req.x);
            FPX_OP_CVTI:  inv = inv || req.x.nan;
            FPX_OP_TRIG:  inv = inv || req.x.inf;
            FPX_OP_CMPO:  inv = inv || req.x.nan || req.y.nan;
            FPX_OP_LOGYX: inv = inv || is_neg_nz(req.x) || (req.y.zero && req.x.inf)
                              || (req.y.zero && req.x.zero) || (req.y.inf && req.x.one);
            FPX_OP_LOGEP: inv = inv || (req.y.inf && req.x.zero);
            default:      inv = inv;
        endcase
        // Datapath hint covers other exact infinities from finite operands
        zdiv = !inv && is_fin(req.x) && is_fin(req.y)
            && (((req.op == FPX_OP_DIV) && req.y.zero && !req.x.zero) || req.exact_inf);
        zsign = (req.op == FPX_OP_DIV) ? (req.x.neg ^ req.y.neg) : req.sign;
        // Integer destinations never report floating overflow or underflow
        ovf = !inv && !zdiv && (req.fmt != FPX_FMT_INT) && !req.res_zero
           && (req.exp > fmt_emax(req.fmt));
        // Exponent here is after rounding, so tininess is judged after rounding
        unf = !inv && !zdiv && (req.fmt != FPX_FMT_INT) && !req.res_zero
           && (req.exp < fmt_emin(req.fmt));
    end

    // Fault record: extended format, fraction trimmed to destination precision
    always_comb begin
        e_adj         = req.exp;
        badj          = 1'b0;
        massive_big   = 1'b0;
        massive_small = 1'b0;
        if (req.exp > `FPX_EXT_EMAX) begin
            e_adj       = req.exp - `FPX_BIAS_ADJ;
            badj        = 1'b1;
            massive_big = e_adj > `FPX_EXT_EMAX;
        end else if (req.exp < `FPX_EXT_EMIN) begin
            e_adj         = req.exp + `FPX_BIAS_ADJ;
            badj          = 1'b1;
            massive_small = e_adj < `FPX_EXT_EMIN;
        end
        e_bsd         = e_adj + `FPX_EXT_BIAS;
        rec_d.sign    = req.sign;
        rec_d.exp     = e_bsd[14:0];
        rec_d.sig     = req.sig & sig_keep(req.fmt);
        rec_d.bias_adj = badj;
        if (massive_big) begin
            rec_d.exp = `FPX_EXP_ALL1;
            rec_d.sig = `FPX_SIG_INF;
        end else if (massive_small) begin
            rec_d.exp = 15'h0000;
            rec_d.sig = 64'h0000_0000_0000_0000;
        end
    end

    // Resolution: substitute a result and set flags, or raise a fault
    logic [`FPX_NUM_EXC-1:0] fset;
    fpx_dst_t                dst_d;
    fpx_flt_t                flt_d;
    logic                    rec_we;

    always_comb begin
        fset   = '0;
        dst_d  = '0;
        flt_d  = FPX_FLT_NONE;
        rec_we = 1'b0;
        if (inv) begin
            if (mask_q[`FPX_BIT_INV]) begin
                dst_d.we   = 1'b1;
                dst_d.data = (req.fmt == FPX_FMT_INT) ? `FPX_INT_MIN : qnan_enc(req.fmt);
                fset[`FPX_BIT_INV] = 1'b1;
            end else begin
                flt_d = FPX_FLT_INV;
            end
        end else if (zdiv) begin
            if (mask_q[`FPX_BIT_ZDIV]) begin
                dst_d.we   = 1'b1;
                dst_d.data = inf_enc(req.fmt, zsign);
                fset[`FPX_BIT_ZDIV] = 1'b1;
            end else begin
                flt_d = FPX_FLT_ZDIV;
            end
        end else if (ovf) begin
            if (!mask_q[`FPX_BIT_OVF]) begin
                rec_we = 1'b1;
                flt_d  = FPX_FLT_OVF;
            end else begin
                fset[`FPX_BIT_OVF] = 1'b1;
                // Masked overflow is always inexact as well
                if (mask_q[`FPX_BIT_INX]) begin
                    dst_d.we   = 1'b1;
                    dst_d.data = req.rnd_res;
                    fset[`FPX_BIT_INX] = 1'b1;
                end else begin
                    rec_we = 1'b1;
                    flt_d  = FPX_FLT_INX;
                end
            end
        end else if (unf) begin
            if (!mask_q[`FPX_BIT_UNF]) begin
                rec_we = 1'b1;
                flt_d  = FPX_FLT_UNF;
            end else if (!req.den_inexact) begin
                dst_d.we   = 1'b1;
                dst_d.data = req.den_res;
            end else begin
                fset[`FPX_BIT_UNF] = 1'b1;
                if (mask_q[`FPX_BIT_INX]) begin
                    dst_d.we   = 1'b1;
                    dst_d.data = req.den_res;
                    fset[`FPX_BIT_INX] = 1'b1;
                end else begin
                    rec_we = 1'b1;
                    flt_d  = FPX_FLT_INX;
                end
            end
        end else begin
            dst_d.we   = 1'b1;
            dst_d.data = req.rnd_res;
            if (req.rnd_inexact) begin
                if (mask_q[`FPX_BIT_INX]) begin
                    fset[`FPX_BIT_INX] = 1'b1;
                end else begin
                    flt_d = FPX_FLT_INX;
                end
            end
        end
        if (!req_valid) begin
            fset   = '0;
            dst_d  = '0;
            flt_d  = FPX_FLT_NONE;
            rec_we = 1'b0;
        end
    end

    // Controls: masks and rounding mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `FPX_MASK_RST;
            rm_q   <= `FPX_RM_RST;
        end else if (wr_done && hit(paddr, `FPX_OFF_ARITH_CTRL)) begin
            mask_q <= pwdata[`FPX_NUM_EXC-1:0];
            rm_q   <= pwdata[`FPX_RM_HI:`FPX_RM_LO];
        end
    end

    // Sticky flags: write one to clear, a new event in the same cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < `FPX_NUM_EXC; gi = gi + 1) begin : g_flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_q[gi] <= 1'(`FPX_FLAGS_RST >> gi);
                end else begin
                    flag_q[gi] <= fset[gi]
                        || (flag_q[gi] && !(wr_done && hit(paddr, `FPX_OFF_FLAGS) && pwdata[gi]));
                end
            end
        end
    endgenerate

    // Fault information area
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_q   <= '0;
            fcode_q <= FPX_FLT_NONE;
        end else begin
            if (rec_we) begin
                rec_q <= rec_d;
            end
            if (flt_d != FPX_FLT_NONE) begin
                fcode_q <= flt_d;
            end
        end
    end

    // Destination write and fault dispatch, one cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_q   <= '0;
            fault_q <= '0;
        end else begin
            dst_q         <= dst_d;
            fault_q.valid <= flt_d != FPX_FLT_NONE;
            fault_q.code  <= flt_d;
        end
    end

    // APB slave: read data is prepared in the setup cycle, so no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            prdata_q  <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign dst        = dst_q;
    assign fault      = fault_q;
    assign round_mode = rm_q;

endmodule : fpx_exception_unit
`default_nettype wire

// *** fpx_exception_unit_properties.sv ***
// Port-level assertions for the FP exception unit
`default_nettype none
`include "fpx_params.svh"
module fpx_checker (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                req_valid,
    input wire fpx_pkg::fpx_req_t   req,
    input wire fpx_pkg::fpx_dst_t   dst,
    input wire fpx_pkg::fpx_fault_t fault,
    input wire logic [1:0]          round_mode
);
    import fpx_pkg::*;
    logic [4:0] mask_q;
    logic [1:0] rm_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `FPX_MASK_RST;
            rm_q   <= `FPX_RM_RST;
        end else if (psel && penable && pready && pwrite && paddr == `FPX_OFF_ARITH_CTRL) begin
            mask_q <= pwdata[4:0];
            rm_q   <= pwdata[9:8];
        end
    end
    sequence snan_req;
        req_valid && req.x.snan;
    endsequence
    sequence inx_alone_req;
        req_valid && req.op == FPX_OP_ADD && req.x == '0 && req.y == '0 && req.exp == '0 && req.rnd_inexact;
    endsequence
    inv_masked_a: assert property (snan_req ##0 (mask_q[0] && req.fmt != FPX_FMT_INT) |=>
        dst.we && !fault.valid && dst.data inside {`FPX_QNAN_SGL, `FPX_QNAN_DBL, `FPX_QNAN_EXT})
        else $error("no QNaN");
    inv_int_a: assert property (req_valid && req.op == FPX_OP_CVTI && req.x.nan && mask_q[0] |=>
        dst.we && dst.data == `FPX_INT_MIN) else $error("bad int min");
    inv_fault_a: assert property (snan_req ##0 !mask_q[0] |=>
        fault.valid && fault.code == FPX_FLT_INV && !dst.we) else $error("no invalid fault");
    zdiv_fault_a: assert property (req_valid && req.op == FPX_OP_DIV && req.y.zero && !req.x.zero
        && !req.x.inf && !req.x.nan && !mask_q[1] |=> fault.valid && fault.code == FPX_FLT_ZDIV && !dst.we)
        else $error("no zdiv fault");
    cvt_no_ovf_a: assert property (req_valid && req.op == FPX_OP_CVTI |=>
        !(fault.valid && fault.code == FPX_FLT_OVF)) else $error("cvt overflow");
    fault_nostore_a: assert property (fault.valid && fault.code != FPX_FLT_INX |->
        !dst.we && $past(req_valid)) else $error("store on fault");
    inx_alone_a: assert property (inx_alone_req ##0 !mask_q[4] |=>
        dst.we && fault.valid && fault.code == FPX_FLT_INX) else $error("bad inexact");
    round_mode_a: assert property (round_mode == rm_q)
        else $error("bad round mode");
endmodule : fpx_checker
bind fpx_exception_unit fpx_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .req_valid, .req, .dst, .fault, .round_mode);
`default_nettype wire

// *** fpx_params.svh ***
// Register offsets, field positions, reset values and numeric limits of the exception unit
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH

`define FPX_OFF_ARITH_CTRL 12'h000
`define FPX_OFF_FLAGS      12'h004
`define FPX_OFF_FINFO      12'h008
`define FPX_OFF_FEXP       12'h00C
`define FPX_OFF_FSIG_LO    12'h010
`define FPX_OFF_FSIG_HI    12'h014

`define FPX_BIT_INV        0
`define FPX_BIT_ZDIV       1
`define FPX_BIT_OVF        2
`define FPX_BIT_UNF        3
`define FPX_BIT_INX        4
`define FPX_NUM_EXC        5
`define FPX_RM_LO          8
`define FPX_RM_HI          9
`define FPX_FFLAGS_LO      8
`define FPX_BIAS_ADJ_BIT   1

`define FPX_MASK_RST       5'h1F
`define FPX_RM_RST         2'h0
`define FPX_FLAGS_RST      5'h00

`define FPX_EXT_EMAX       20'sh0_3FFF
`define FPX_EXT_EMIN       (-20'sh0_3FFE)
`define FPX_EXT_BIAS       20'sh0_3FFF
`define FPX_BIAS_ADJ       20'sh0_6000
`define FPX_SGL_EMAX       20'sh0_007F
`define FPX_SGL_EMIN       (-20'sh0_007E)
`define FPX_DBL_EMAX       20'sh0_03FF
`define FPX_DBL_EMIN       (-20'sh0_03FE)

`define FPX_QNAN_SGL       80'h0000_0000_0000_7FC0_0000
`define FPX_QNAN_DBL       80'h0000_7FF8_0000_0000_0000
`define FPX_QNAN_EXT       80'h7FFF_C000_0000_0000_0000
`define FPX_INF_SGL        80'h0000_0000_0000_7F80_0000
`define FPX_INF_DBL        80'h0000_7FF0_0000_0000_0000
`define FPX_INF_EXT        80'h7FFF_8000_0000_0000_0000
`define FPX_INT_MIN        80'h0000_8000_0000_0000_0000
`define FPX_SIG_KEEP_SGL   64'hFFFF_FF00_0000_0000
`define FPX_SIG_KEEP_DBL   64'hFFFF_FFFF_FFFF_F800
`define FPX_SIG_INF        64'h8000_0000_0000_0000
`define FPX_EXP_ALL1       15'h7FFF

`endif

// *** fpx_pkg.sv ***
// Types shared by the floating-point exception unit
`default_nettype none
package fpx_pkg;

    typedef logic signed [19:0] fpx_exp_t;

    typedef enum logic [1:0] {
        FPX_FMT_SGL = 2'h0,
        FPX_FMT_DBL = 2'h1,
        FPX_FMT_EXT = 2'h2,
        FPX_FMT_INT = 2'h3
    } fpx_fmt_t;

    typedef enum logic [3:0] {
        FPX_OP_ADD   = 4'h0,
        FPX_OP_SUB   = 4'h1,
        FPX_OP_MUL   = 4'h2,
        FPX_OP_DIV   = 4'h3,
        FPX_OP_REM   = 4'h4,
        FPX_OP_SQRT  = 4'h5,
        FPX_OP_CVTI  = 4'h6,
        FPX_OP_TRIG  = 4'h7,
        FPX_OP_LOGYX = 4'h8,
        FPX_OP_LOGEP = 4'h9,
        FPX_OP_CMPO  = 4'hA,
        FPX_OP_SCALE = 4'hB,
        FPX_OP_OTHER = 4'hC
    } fpx_op_t;

    typedef enum logic [2:0] {
        FPX_FLT_NONE = 3'h0,
        FPX_FLT_INV  = 3'h1,
        FPX_FLT_ZDIV = 3'h2,
        FPX_FLT_OVF  = 3'h3,
        FPX_FLT_UNF  = 3'h4,
        FPX_FLT_INX  = 3'h5
    } fpx_flt_t;

    typedef struct packed {
        logic nan;
        logic snan;
        logic inf;
        logic zero;
        logic neg;
        logic one;
    } fpx_cls_t;

    typedef struct packed {
        fpx_op_t     op;
        fpx_fmt_t    fmt;
        fpx_cls_t    x;
        fpx_cls_t    y;
        logic        exact_inf;
        logic        res_zero;
        logic        sign;
        fpx_exp_t    exp;
        logic [63:0] sig;
        logic [79:0] rnd_res;
        logic        rnd_inexact;
        logic [79:0] den_res;
        logic        den_inexact;
    } fpx_req_t;

    typedef struct packed {
        logic        we;
        logic [79:0] data;
    } fpx_dst_t;

    typedef struct packed {
        logic     valid;
        fpx_flt_t code;
    } fpx_fault_t;

    typedef struct packed {
        logic        sign;
        logic [14:0] exp;
        logic [63:0] sig;
        logic        bias_adj;
    } fpx_rec_t;

endpackage : fpx_pkg
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the FP exception unit
`default_nettype none
`include "fpx_params.svh"
module automatic testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fpx_pkg::*;
    localparam logic [5:0] SN = 6'h30, QN = 6'h20, IN = 6'h08, ZE = 6'h04, NG = 6'h02, ON = 6'h01;
    localparam logic [11:0] CT = `FPX_OFF_ARITH_CTRL, FL = `FPX_OFF_FLAGS, FI = `FPX_OFF_FINFO, FE = `FPX_OFF_FEXP;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [1:0]  round_mode;
    fpx_req_t    req;
    fpx_dst_t    dst;
    fpx_fault_t  fault;
    int          num_errors = 0, compares = 0;
    fpx_exception_unit i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                              .pready, .pslverr, .req_valid, .req, .dst, .fault, .round_mode);
    fpx_dpath_model i_dp (.pclk, .req_valid, .req);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task chk(input string what, input logic [79:0] e, g);
        compares++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", what, e, g);
            num_errors++;
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        chk("pready", 1'b1, pready);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] x = 32'h0000_0000, input logic xe = 1'b0);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", x, rq);
        chk("pslverr", xe, re);
    endtask : rd
    task rearm(input logic [4:0] m);
        wr(FL, 32'h0000_001F);
        wr(CT, {27'h000_0000, m});
    endtask : rearm
    function fpx_req_t mk(fpx_op_t o, fpx_fmt_t f, logic [5:0] x = 6'h00, logic [5:0] y = 6'h00);
        mk = '0;
        {mk.op, mk.fmt, mk.x, mk.y} = {o, f, x, y};
    endfunction : mk
    task op(input fpx_req_t r, input logic we, input logic [79:0] d, input logic fv = 1'b0,
            input fpx_flt_t c = FPX_FLT_NONE);
        i_dp.send(r);
        #1;
        chk("dst.we", we, dst.we);
        if (we) chk("dst.data", d, dst.data);
        chk("fault.valid", fv, fault.valid);
        if (fv) chk("fault.code", c, fault.code);
        @(posedge pclk);
    endtask : op
    task t_regs();
        rd(CT, 32'h0000_001F);
        rd(FL);
        rd(12'h020, 32'h0000_0000, 1'b1);
        wr(CT, 32'h0000_021F);
        chk("round_mode", 2'h2, round_mode);
        wr(CT, 32'h0000_001F);
        $display("t_regs done");
    endtask : t_regs
    task t_inv();
        fpx_op_t    o[14] = '{FPX_OP_ADD, FPX_OP_SUB, FPX_OP_MUL, FPX_OP_DIV, FPX_OP_DIV, FPX_OP_REM, FPX_OP_REM,
            FPX_OP_SQRT, FPX_OP_TRIG, FPX_OP_LOGYX, FPX_OP_LOGYX, FPX_OP_LOGYX, FPX_OP_LOGYX, FPX_OP_LOGEP};
        logic [5:0] x[14] = '{IN, IN, ZE, ZE, IN, ON, IN, NG, IN, NG, IN, ZE, ON, ZE};
        logic [5:0] y[14] = '{IN | NG, IN, IN, ZE, IN, ZE, ON, 6'h00, 6'h00, ON, ZE, ZE, IN, IN};
        foreach (o[i]) op(mk(o[i], FPX_FMT_EXT, x[i], y[i]), 1, `FPX_QNAN_EXT);
        op(mk(FPX_OP_MUL, FPX_FMT_SGL, SN), 1, `FPX_QNAN_SGL);
        op(mk(FPX_OP_ADD, FPX_FMT_DBL, SN), 1, `FPX_QNAN_DBL);
        op(mk(FPX_OP_CVTI, FPX_FMT_INT, QN), 1, `FPX_INT_MIN);
        rd(FL, 32'h0000_0001);
        rearm(5'h1E);
        op(mk(FPX_OP_ADD, FPX_FMT_EXT, SN), 0, 0, 1, FPX_FLT_INV);
        op(mk(FPX_OP_CMPO, FPX_FMT_EXT, QN, ON), 0, 0, 1, FPX_FLT_INV);
        rd(FL);
        wr(CT, 32'h0000_001F);
        $display("t_inv done");
    endtask : t_inv
    task t_zdiv();
        fpx_req_t r = mk(FPX_OP_DIV, FPX_FMT_EXT, NG, ZE);
        op(r, 1, 80'hFFFF_8000_0000_0000_0000);
        rd(FL, 32'h0000_0002);
        rearm(5'h1D);
        op(r, 0, 0, 1, FPX_FLT_ZDIV);
        rd(FL);
        wr(CT, 32'h0000_001F);
        $display("t_zdiv done");
    endtask : t_zdiv
    task t_ovf();
        fpx_req_t r = mk(FPX_OP_MUL, FPX_FMT_SGL);
        r.exp = 20'sh0_00C8;
        r.rnd_res = `FPX_INF_SGL;
        r.rnd_inexact = 1'b1;
        op(r, 1, `FPX_INF_SGL);
        rd(FL, 32'h0000_0014);
        rearm(5'h1B);
        r.exp = 20'sh0_4E20;
        r.sig = 64'hABCD_EF12_3456_789A;
        r.rnd_inexact = 1'b0;
        op(r, 0, 0, 1, FPX_FLT_OVF);
        rd(FI, 32'h0000_0203);
        rd(FE, 32'h0000_2E1F);
        rd(`FPX_OFF_FSIG_HI, 32'hABCD_EF00);
        rd(`FPX_OFF_FSIG_LO);
        rd(FL);
        r = mk(FPX_OP_SCALE, FPX_FMT_EXT);
        r.exp = 20'sh0_C000;
        op(r, 0, 0, 1, FPX_FLT_OVF);
        rd(FE, 32'h0000_7FFF);
        wr(CT, 32'h0000_000F);
        r = mk(FPX_OP_MUL, FPX_FMT_SGL);
        r.exp = 20'sh0_00C8;
        r.rnd_inexact = 1'b1;
        op(r, 0, 0, 1, FPX_FLT_INX);
        rd(FL, 32'h0000_0004);
        rearm(5'h1F);
        $display("t_ovf done");
    endtask : t_ovf
    task t_unf();
        fpx_req_t r = mk(FPX_OP_MUL, FPX_FMT_DBL);
        r.exp = 20'shF_FBB4;
        r.sig = 64'h8000_0000_0000_0000;
        r.den_res = 80'h0000_0000_0000_0000_1234;
        op(r, 1, r.den_res);
        rd(FL);
        r.den_inexact = 1'b1;
        op(r, 1, r.den_res);
        rd(FL, 32'h0000_0018);
        rearm(5'h17);
        r.fmt = FPX_FMT_EXT;
        r.exp = 20'shF_B1E0;
        op(r, 0, 0, 1, FPX_FLT_UNF);
        rd(FI, 32'h0000_0204);
        rd(FE, 32'h0000_51DF);
        rd(FL);
        r.op = FPX_OP_SCALE;
        r.exp = 20'shF_3CB0;
        op(r, 0, 0, 1, FPX_FLT_UNF);
        rd(FE);
        wr(CT, 32'h0000_001F);
        $display("t_unf done");
    endtask : t_unf
    task t_inx();
        fpx_req_t r = mk(FPX_OP_ADD, FPX_FMT_EXT);
        r.rnd_res = 80'h3FFF_8000_0000_0000_0001;
        r.rnd_inexact = 1'b1;
        wr(CT, 32'h0000_000F);
        op(r, 1, r.rnd_res, 1, FPX_FLT_INX);
        rd(FL);
        wr(CT, 32'h0000_001F);
        op(r, 1, r.rnd_res);
        rd(FL, 32'h0000_0010);
        r.rnd_inexact = 1'b0;
        op(r, 1, r.rnd_res);
        wr(FL, 32'h0000_000F);
        rd(FL, 32'h0000_0010);
        wr(FL, 32'h0000_0010);
        rd(FL);
        $display("t_inx done");
    endtask : t_inx
    task finish_test();
        $display("Comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        #200_000;
        num_errors++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_inv();
        t_zdiv();
        t_ovf();
        t_unf();
        t_inx();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
